// [verilog/lpi_consts.svh]
// Constants for the low-power DRAM power-up sequencer
`ifndef LPI_CONSTS_SVH
`define LPI_CONSTS_SVH
`define LPI_CLK_PERIOD_PS      32'd5000
`define LPI_RAMP_HOLD_NS       32'd100
`define LPI_CLK_STABLE_CYC     32'd5
`define LPI_POST_ENABLE_US     32'd200
`define LPI_POST_RESET_US      32'd1
`define LPI_MAX_SELF_INIT_US   32'd10
`define LPI_CAL_TIME_US        32'd1
`define LPI_CYC_NS(t)  (((t) * 32'd1000 + `LPI_CLK_PERIOD_PS - 32'd1) / `LPI_CLK_PERIOD_PS)
`define LPI_CYC_US(t)  (((t) * 32'd1000000 + `LPI_CLK_PERIOD_PS - 32'd1) / `LPI_CLK_PERIOD_PS)
`define LPI_MA_INFO            8'h00
`define LPI_MA_FEAT1           8'h01
`define LPI_MA_FEAT2           8'h02
`define LPI_MA_IOCFG           8'h03
`define LPI_MA_CAL             8'h0a
`define LPI_MA_TERM            8'h0b
`define LPI_MA_RESET           8'h3f
`define LPI_CAL_INIT_CODE      8'hff
`define LPI_BUSY_BIT           0
`endif

// [verilog/lpi_pkg.sv]
// Types for the low-power DRAM power-up sequencer
package lpi_pkg;
	typedef enum logic [2:0] {
		LPI_CMD_NOP,
		LPI_CMD_MRW,
		LPI_CMD_MRR,
		LPI_CMD_PREA
	} lpi_cmd_t;
	typedef enum logic [3:0] {
		LPI_ST_RAMP,
		LPI_ST_CKSTAB,
		LPI_ST_NOP1,
		LPI_ST_RESET,
		LPI_ST_NOP2,
		LPI_ST_POLL,
		LPI_ST_POLLWAIT,
		LPI_ST_CAL,
		LPI_ST_CALWAIT,
		LPI_ST_CFG,
		LPI_ST_DONE
	} lpi_state_t;
endpackage

// [verilog/lpi_cmd_if.sv]
// Command channel between sequencer and CA bus encoder
`timescale 1ns/1ps
interface lpi_cmd_if;
	logic                kind;
	logic                valid;
	lpi_pkg::lpi_cmd_t   cmd;
	logic [7:0]          addr;
	logic [7:0]          data;
	modport seq (output valid, output cmd, output addr, output data, input kind);
	modport enc (input valid, input cmd, input addr, input data, output kind);
endinterface

// [verilog/lpi_ca_enc.sv]
// Encodes one command into CA pin words and chip select
`timescale 1ns/1ps
module lpi_ca_enc
(
	input  wire logic       mclk,
	input  wire logic       rst,
	lpi_cmd_if.enc          cmdIf,
	output logic [9:0]      caRise,
	output logic [9:0]      caFall,
	output logic            csN
);
	typedef struct packed {
		logic [9:0] rise;
		logic [9:0] fall;
		logic       cs;
	} lpi_enc_t;
	lpi_enc_t r_q;
	lpi_enc_t r_d;
	assign cmdIf.kind = 1'b0;
	always_comb
	begin
		r_d = '{rise: 10'h3ff, fall: 10'h3ff, cs: 1'b0};
		if (cmdIf.valid)
		begin
			r_d.cs = 1'b1;
			unique case (cmdIf.cmd)
				lpi_pkg::LPI_CMD_MRW:
				begin
					r_d.rise = {cmdIf.addr[5:0], 4'h0};
					r_d.fall = {cmdIf.data, cmdIf.addr[7:6]};
				end
				lpi_pkg::LPI_CMD_MRR:
				begin
					r_d.rise = {cmdIf.addr[5:0], 4'h8};
					r_d.fall = {8'h00, cmdIf.addr[7:6]};
				end
				lpi_pkg::LPI_CMD_PREA:
				begin
					r_d.rise = 10'h01b;
					r_d.fall = 10'h000;
				end
				default:
				begin
					r_d.cs = 1'b0;
				end
			endcase
		end
	end
	always_ff @(posedge mclk)
	begin
		if (rst)
			r_q <= '{rise: 10'h3ff, fall: 10'h3ff, cs: 1'b0};
		else
			r_q <= r_d;
	end
	assign caRise = r_q.rise;
	assign caFall = r_q.fall;
	assign csN    = ~r_q.cs;
endmodule

// [verilog/lpi_init_seq.sv]
// Power-up and re-initialization sequencer driving the DRAM pins
`timescale 1ns/1ps
`include "lpi_consts.svh"
module lpi_init_seq
#(
	parameter int unsigned RAMP_HOLD_CYC  = `LPI_CYC_NS(`LPI_RAMP_HOLD_NS),
	parameter int unsigned CLK_STABLE_CYC = `LPI_CLK_STABLE_CYC,
	parameter int unsigned POST_EN_CYC    = `LPI_CYC_US(`LPI_POST_ENABLE_US),
	parameter int unsigned POST_RST_CYC   = `LPI_CYC_US(`LPI_POST_RESET_US),
	parameter int unsigned SELF_INIT_CYC  = `LPI_CYC_US(`LPI_MAX_SELF_INIT_US),
	parameter int unsigned CAL_CYC        = `LPI_CYC_US(`LPI_CAL_TIME_US),
	parameter int unsigned POLL_GAP_CYC   = 32,
	parameter int unsigned CNT_W          = 20
)
(
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic       suppliesOk,
	input  wire logic       usePolling,
	input  wire logic       reinitReq,
	input  wire logic       calGrant,
	input  wire logic       termLevel,
	input  wire logic [7:0] feat1Val,
	input  wire logic [7:0] feat2Val,
	input  wire logic [7:0] ioCfgVal,
	input  wire logic       readValid,
	input  wire logic [7:0] readData,
	output logic            clkEnable,
	output logic            memClkRun,
	output logic            csN,
	output logic [9:0]      caRise,
	output logic [9:0]      caFall,
	output logic            termOut,
	output logic            calReq,
	output logic            initDone,
	output logic            busyFlagSeen
);
	// Read-back pins and the supply monitor arrive from outside the clock domain
	logic       supOkS1;
	logic       supOkS2;
	logic       rdValidS1;
	logic       rdValidS2;
	logic [7:0] rdDataS1;
	logic [7:0] rdDataS2;

	typedef struct packed {
		lpi_pkg::lpi_state_t st;
		logic [CNT_W-1:0]    cnt;
		logic [CNT_W-1:0]    initCnt;
		logic [1:0]          cfgIdx;
		logic                cke;
		logic                clkRun;
		logic                term;
		logic                cal;
		logic                done;
		logic                busy;
		logic                pollOut;
	} lpi_seq_t;

	lpi_seq_t s_q;
	lpi_seq_t s_d;
	lpi_cmd_if cmdIf ();

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			supOkS1   <= 1'b0;
			supOkS2   <= 1'b0;
			rdValidS1 <= 1'b0;
			rdValidS2 <= 1'b0;
			rdDataS1  <= 8'h00;
			rdDataS2  <= 8'h00;
		end
		else
		begin
			supOkS1   <= suppliesOk;
			supOkS2   <= supOkS1;
			rdValidS1 <= readValid;
			rdValidS2 <= rdValidS1;
			rdDataS1  <= readData;
			rdDataS2  <= rdDataS1;
		end
	end

	always_comb
	begin
		s_d          = s_q;
		cmdIf.valid  = 1'b0;
		cmdIf.cmd    = lpi_pkg::LPI_CMD_NOP;
		cmdIf.addr   = 8'h00;
		cmdIf.data   = 8'h00;
		if (s_q.cnt != '0)
			s_d.cnt = s_q.cnt - 1'b1;
		if (s_q.initCnt != '0)
			s_d.initCnt = s_q.initCnt - 1'b1;
		unique case (s_q.st)
			lpi_pkg::LPI_ST_RAMP:
			begin
				s_d.cke = 1'b0;
				if (!supOkS2)
					s_d.cnt = CNT_W'(RAMP_HOLD_CYC);
				else if (s_q.cnt == '0)
				begin
					s_d.clkRun = 1'b1;
					s_d.cnt    = CNT_W'(CLK_STABLE_CYC);
					s_d.st     = lpi_pkg::LPI_ST_CKSTAB;
				end
			end
			lpi_pkg::LPI_ST_CKSTAB:
			begin
				if (s_q.cnt == '0)
				begin
					s_d.cke  = 1'b1;
					s_d.term = termLevel;
					s_d.cnt  = CNT_W'(POST_EN_CYC);
					s_d.st   = lpi_pkg::LPI_ST_NOP1;
				end
			end
			lpi_pkg::LPI_ST_NOP1:
			begin
				if (s_q.cnt == '0)
				begin
					cmdIf.valid = 1'b1;
					cmdIf.cmd   = lpi_pkg::LPI_CMD_PREA;
					s_d.st      = lpi_pkg::LPI_ST_RESET;
				end
			end
			lpi_pkg::LPI_ST_RESET:
			begin
				cmdIf.valid = 1'b1;
				cmdIf.cmd   = lpi_pkg::LPI_CMD_MRW;
				cmdIf.addr  = `LPI_MA_RESET;
				s_d.cnt     = CNT_W'(POST_RST_CYC);
				s_d.initCnt = CNT_W'(SELF_INIT_CYC);
				// Busy is armed here so a clear left from an earlier run cannot skip the wait
				s_d.busy    = 1'b1;
				s_d.done    = 1'b0;
				s_d.st      = lpi_pkg::LPI_ST_NOP2;
			end
			lpi_pkg::LPI_ST_NOP2:
			begin
				if (s_q.cnt == '0)
					s_d.st = lpi_pkg::LPI_ST_POLL;
			end
			lpi_pkg::LPI_ST_POLL:
			begin
				// Only reads here; a fixed wait covers the polling-disabled case
				if (s_q.initCnt == '0 || !s_q.busy)
				begin
					// No CA training: calibration follows the idle state directly
					s_d.st = lpi_pkg::LPI_ST_CAL;
				end
				// Reads are legal only while the system runs the boot clock in range
				else if (usePolling)
				begin
					cmdIf.valid = 1'b1;
					cmdIf.cmd   = lpi_pkg::LPI_CMD_MRR;
					cmdIf.addr  = `LPI_MA_INFO;
					s_d.cnt     = CNT_W'(POLL_GAP_CYC);
					s_d.pollOut = 1'b1;
					s_d.st      = lpi_pkg::LPI_ST_POLLWAIT;
				end
			end
			lpi_pkg::LPI_ST_POLLWAIT:
			begin
				if (s_q.pollOut && rdValidS2)
				begin
					s_d.busy    = rdDataS2[`LPI_BUSY_BIT];
					s_d.pollOut = 1'b0;
				end
				// The gap must cover the read burst and its return path; pollOut stays set, so a later answer can be taken for the next read
				if (s_q.cnt == '0)
					s_d.st = lpi_pkg::LPI_ST_POLL;
			end
			lpi_pkg::LPI_ST_CAL:
			begin
				// Request stays up through the grant until the calibration wait ends
				s_d.cal = 1'b1;
				if (calGrant && s_q.cal)
				begin
					cmdIf.valid = 1'b1;
					cmdIf.cmd   = lpi_pkg::LPI_CMD_MRW;
					cmdIf.addr  = `LPI_MA_CAL;
					cmdIf.data  = `LPI_CAL_INIT_CODE;
					s_d.cnt     = CNT_W'(CAL_CYC);
					s_d.st      = lpi_pkg::LPI_ST_CALWAIT;
				end
			end
			lpi_pkg::LPI_ST_CALWAIT:
			begin
				if (s_q.cnt == '0)
				begin
					s_d.cal    = 1'b0;
					s_d.cfgIdx = 2'd0;
					s_d.st     = lpi_pkg::LPI_ST_CFG;
				end
			end
			lpi_pkg::LPI_ST_CFG:
			begin
				cmdIf.valid = 1'b1;
				cmdIf.cmd   = lpi_pkg::LPI_CMD_MRW;
				// Training and leveling entries are never written, so no exit write is owed
				unique case (s_q.cfgIdx)
					2'd0:
					begin
						cmdIf.addr = `LPI_MA_FEAT1;
						cmdIf.data = feat1Val;
					end
					2'd1:
					begin
						cmdIf.addr = `LPI_MA_FEAT2;
						cmdIf.data = feat2Val;
					end
					default:
					begin
						cmdIf.addr = `LPI_MA_IOCFG;
						cmdIf.data = ioCfgVal;
					end
				endcase
				s_d.cfgIdx = s_q.cfgIdx + 2'd1;
				if (s_q.cfgIdx == 2'd2)
				begin
					s_d.done = 1'b1;
					s_d.st   = lpi_pkg::LPI_ST_DONE;
				end
			end
			lpi_pkg::LPI_ST_DONE:
			begin
				if (reinitReq)
					s_d.st = lpi_pkg::LPI_ST_RESET;
			end
			default:
			begin
				s_d.st = lpi_pkg::LPI_ST_RAMP;
			end
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			s_q    <= '0;
			s_q.st <= lpi_pkg::LPI_ST_RAMP;
		end
		else
			s_q <= s_d;
	end

	// Encoder registers the command, so the pins lag the issuing state by one cycle
	lpi_ca_enc u_enc
	(
		.mclk   (mclk),
		.rst    (rst),
		.cmdIf  (cmdIf),
		.caRise (caRise),
		.caFall (caFall),
		.csN    (csN)
	);

	// All status outputs come straight from the state register; csN and the CA words come from the encoder register
	assign clkEnable    = s_q.cke;
	assign memClkRun    = s_q.clkRun;
	assign termOut      = s_q.term;
	assign calReq       = s_q.cal;
	assign initDone     = s_q.done;
	assign busyFlagSeen = s_q.busy;

	// Checks of the power-up order on the pins and on the sequencer state
	ramp_cke_low_a: assert property (@(posedge mclk) disable iff (rst)
		(s_q.st == lpi_pkg::LPI_ST_RAMP) |-> !clkEnable)
		else $error("enable high during ramp hold");

	stable_clk_a: assert property (@(posedge mclk) disable iff (rst)
		$rose(clkEnable) |-> $past(memClkRun, 5))
		else $error("enable raised before clock stable");

	cke_held_a: assert property (@(posedge mclk) disable iff (rst)
		clkEnable |=> clkEnable)
		else $error("enable dropped after rising");

	term_static_a: assert property (@(posedge mclk) disable iff (rst)
		(clkEnable && $past(clkEnable)) |-> $stable(termOut))
		else $error("termination input changed during init");

	term_capture_a: assert property (@(posedge mclk) disable iff (rst)
		$rose(clkEnable) |-> (termOut == $past(termLevel)))
		else $error("termination level not captured at enable");

	nop_after_en_a: assert property (@(posedge mclk) disable iff (rst)
		$rose(clkEnable) |-> csN [*8])
		else $error("command issued during enable NOP window");

	nop1_quiet_a: assert property (@(posedge mclk) disable iff (rst)
		(s_q.st == lpi_pkg::LPI_ST_NOP1 && s_q.cnt != '0) |=> csN)
		else $error("command issued before enable wait ended");

	reset_order_a: assert property (@(posedge mclk) disable iff (rst)
		(s_q.st == lpi_pkg::LPI_ST_RESET)
		|-> ($past(s_q.st) == lpi_pkg::LPI_ST_NOP1 || $past(s_q.st) == lpi_pkg::LPI_ST_DONE))
		else $error("reset command out of order");

	reset_nop_a: assert property (@(posedge mclk) disable iff (rst)
		(s_q.st == lpi_pkg::LPI_ST_NOP2) |=> csN)
		else $error("command issued during post-reset NOP window");

	busy_armed_a: assert property (@(posedge mclk) disable iff (rst)
		(s_q.st == lpi_pkg::LPI_ST_NOP2) |-> busyFlagSeen)
		else $error("busy flag not armed after reset command");

	poll_read_a: assert property (@(posedge mclk) disable iff (rst)
		((s_q.st == lpi_pkg::LPI_ST_POLL || s_q.st == lpi_pkg::LPI_ST_POLLWAIT) && !csN)
		|-> caRise[3:0] == 4'h8)
		else $error("non-read command before self-init done");

	poll_gap_a: assert property (@(posedge mclk) disable iff (rst)
		(s_q.st == lpi_pkg::LPI_ST_POLLWAIT && s_q.cnt != '0) |=> csN)
		else $error("command issued while a read returns");

	cal_idle_a: assert property (@(posedge mclk) disable iff (rst)
		(cmdIf.valid && cmdIf.addr == `LPI_MA_CAL) |-> (!busyFlagSeen || s_q.initCnt == '0))
		else $error("calibration issued before device idle");

	cal_grant_a: assert property (@(posedge mclk) disable iff (rst)
		(cmdIf.valid && cmdIf.addr == `LPI_MA_CAL) |-> calGrant && calReq)
		else $error("calibration issued without grant");

	cal_wait_a: assert property (@(posedge mclk) disable iff (rst)
		(s_q.st == lpi_pkg::LPI_ST_CALWAIT) |=> csN)
		else $error("command issued during calibration wait");

	cfg_order_a: assert property (@(posedge mclk) disable iff (rst)
		$fell(calReq) |=> (s_q.st == lpi_pkg::LPI_ST_CFG) ##3 initDone)
		else $error("configuration writes not completed");

	done_after_cfg_a: assert property (@(posedge mclk) disable iff (rst)
		$rose(initDone) |-> $past(s_q.st) == lpi_pkg::LPI_ST_CFG)
		else $error("init done without configuration writes");

	reinit_restart_a: assert property (@(posedge mclk) disable iff (rst)
		(s_q.st == lpi_pkg::LPI_ST_DONE && reinitReq) |=> ##1 (!csN && caRise == 10'h3f0))
		else $error("re-init did not restart at reset command");
endmodule

// [bench/lpi_dev_model.sv]
// Behavioural memory device: busy flag, mode reads, termination state
`timescale 1ns/1ps
module lpi_dev_model
#(
	parameter int unsigned INIT_CYC = 12
)
(
	input  wire logic       mclk,
	input  wire logic       clkEnable,
	input  wire logic       csN,
	input  wire logic [9:0] caRise,
	output logic            readValid,
	output logic [7:0]      readData,
	output logic            busy,
	output logic            termOn
);
	logic [1:0]  pend = 2'b00;
	logic [15:0] initCnt = 16'h0000;
	initial
	begin
		readValid = 1'b0;
		readData = 8'h00;
		busy = 1'b1;
		termOn = 1'b0;
	end
	always @(posedge mclk)
	begin
		// Only the mode address is decoded; low column bits are implied zero
		pend <= {pend[0], clkEnable && !csN && caRise == 10'h008};
		// No answer at all while clock enable is low
		readValid <= clkEnable && pend[1];
		// Off-cycle data toggles so a stale value never looks valid
		readData <= pend[1] ? {7'h00, busy} : ~readData;
		if (!csN && caRise == 10'h3f0)
		begin
			busy <= 1'b1;
			initCnt <= 16'(INIT_CYC);
			termOn <= 1'b0;
		end
		else if (initCnt != 16'h0000)
			initCnt <= initCnt - 16'h0001;
		else
			busy <= 1'b0;
		if (!csN && caRise == 10'h0b0)
			termOn <= 1'b1;
	end
endmodule

// [bench/tb_top.sv]
// Self-checking bench for the power-up sequencer
`timescale 1ns/1ps
`include "lpi_consts.svh"
module tb_top;
	localparam int RAMP = 3;
	localparam int POSTEN = 50;
	localparam int POSTRST = 5;
	localparam int SELFINIT = 20;
	localparam int CALT = 5;
	logic        mclk, rst, suppliesOk, usePolling, reinitReq, calGrant, termLevel;
	logic [7:0]  feat1Val, feat2Val, ioCfgVal, readData;
	logic        readValid, clkEnable, memClkRun, csN, termOut, calReq, initDone;
	logic        busyFlagSeen, devBusy, supPrev, termHold;
	logic [9:0]  caRise, caFall;
	logic [2:0]  grantHist;
	logic [20:0] q[$];
	logic [20:0] e;
	int          seed, nMismatch, totalChecks, cyc, supCyc, runCyc, enCyc, lastCyc, lastKind;
	lpi_init_seq #(.RAMP_HOLD_CYC(RAMP), .POST_EN_CYC(POSTEN), .POST_RST_CYC(POSTRST),
		.SELF_INIT_CYC(SELFINIT), .CAL_CYC(CALT), .POLL_GAP_CYC(8)) u_dut (.mclk(mclk),
		.rst(rst), .suppliesOk(suppliesOk), .usePolling(usePolling), .reinitReq(reinitReq),
		.calGrant(calGrant), .termLevel(termLevel), .feat1Val(feat1Val), .feat2Val(feat2Val),
		.ioCfgVal(ioCfgVal), .readValid(readValid), .readData(readData), .clkEnable(clkEnable),
		.memClkRun(memClkRun), .csN(csN), .caRise(caRise), .caFall(caFall), .termOut(termOut),
		.calReq(calReq), .initDone(initDone), .busyFlagSeen(busyFlagSeen));
	lpi_dev_model u_dev (.mclk(mclk), .clkEnable(clkEnable), .csN(csN), .caRise(caRise),
		.readValid(readValid), .readData(readData), .busy(devBusy), .termOn());
	initial
	begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		totalChecks++;
		if (got !== exp)
		begin
			nMismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic endSim();
		$display("checks=%0d mismatches=%0d", totalChecks, nMismatch);
		if (nMismatch == 0 && totalChecks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Top bit set: the falling half carries data worth comparing
	task automatic note(input logic [7:0] a, input logic [7:0] d, input logic full);
		q.push_back({full, a[5:0], 4'h0, d, a[7:6]});
	endtask
	task automatic run_init(input logic poll, input logic again);
		int i;
		usePolling <= poll;
		feat1Val <= 8'($random(seed));
		feat2Val <= 8'($random(seed));
		ioCfgVal <= 8'($random(seed));
		termLevel <= 1'($random(seed));
		@(posedge mclk);
		note(`LPI_MA_RESET, 8'h00, 1'b0);
		note(`LPI_MA_CAL, `LPI_CAL_INIT_CODE, 1'b1);
		note(`LPI_MA_FEAT1, feat1Val, 1'b1);
		note(`LPI_MA_FEAT2, feat2Val, 1'b1);
		note(`LPI_MA_IOCFG, ioCfgVal, 1'b1);
		if (again)
			reinitReq <= 1'b1;
		else
			suppliesOk <= 1'b1;
		@(posedge mclk);
		reinitReq <= 1'b0;
		for (i = 0; i < 1500 && !(q.size() == 0 && initDone === 1'b1); i++)
			@(posedge mclk);
		chk(initDone, 1'b1);
		if (poll)
			chk(busyFlagSeen, 1'b0);
	endtask
	always @(posedge mclk)
		calGrant <= calReq && (calGrant || ($random(seed) % 4 == 0));
	always @(posedge mclk)
	begin
		cyc++;
		grantHist = {grantHist[1:0], calGrant};
		if (suppliesOk && !supPrev)
			supCyc = cyc;
		supPrev = suppliesOk;
		if (rst)
		begin
			lastKind = 0;
			enCyc = 0;
			runCyc = 0;
		end
		else
		begin
			if (memClkRun && runCyc == 0)
				runCyc = cyc;
			if (clkEnable && enCyc == 0)
			begin
				enCyc = cyc;
				lastCyc = cyc;
				termHold = termOut;
				chk(32'(cyc - supCyc >= RAMP), 1);
				chk(32'(cyc - runCyc >= 5), 1);
			end
			if (enCyc != 0)
				chk(termOut, termHold);
			if (!csN)
			begin
				if (lastKind == 0)
					chk(32'(cyc - lastCyc >= POSTEN), 1);
				if (lastKind == 1)
					chk(32'(cyc - lastCyc >= (usePolling ? POSTRST : SELFINIT)), 1);
				if (lastKind == 2)
					chk(32'(cyc - lastCyc >= CALT), 1);
				lastCyc = cyc;
				lastKind = (caRise == 10'h3f0) ? 1 : (caRise == 10'h0a0) ? 2 : 3;
				if (caRise == 10'h008)
					chk(usePolling, 1'b1);
				if (lastKind == 2)
				begin
					chk(32'(grantHist != 3'b000), 1);
					chk(calReq, 1'b1);
					chk(devBusy, 1'b0);
				end
				if (caRise[3:0] == 4'h0 && q.size() == 0)
					chk(caRise, 10'h3ff);
				else if (caRise[3:0] == 4'h0)
				begin
					e = q.pop_front();
					chk({caRise, e[20] ? caFall : e[9:0]}, e[19:0]);
				end
			end
		end
		if (cyc > 6000)
		begin
			nMismatch++;
			endSim();
		end
	end
	initial
	begin
		seed = 58;
		rst = 1'b1;
		suppliesOk = 1'b0;
		usePolling = 1'b0;
		reinitReq = 1'b0;
		calGrant = 1'b0;
		termLevel = 1'b0;
		feat1Val = 8'h00;
		feat2Val = 8'h00;
		ioCfgVal = 8'h00;
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		run_init(1'b1, 1'b0);
		run_init(1'b0, 1'b1);
		// Reset while the post-enable wait is running
		suppliesOk <= 1'b0;
		rst <= 1'b1;
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		suppliesOk <= 1'b1;
		repeat (40) @(posedge mclk);
		rst <= 1'b1;
		suppliesOk <= 1'b0;
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		q.delete();
		run_init(1'b0, 1'b0);
		endSim();
	end
endmodule
